// ---- inc/idc_defs.svh ----
// constants for the instruction decoder: fields, opcodes, timing
`ifndef IDC_DEFS_SVH
`define IDC_DEFS_SVH
`define IDC_WORD_W        14
`define IDC_QPHASES       4
`define IDC_CLK_PERIOD_NS 100
`define IDC_FILE_HI       6
`define IDC_DEST_BIT      7
`define IDC_BIT_HI        9
`define IDC_BIT_LO        7
`define IDC_LIT8_HI       7
`define IDC_LIT11_HI      10
`define IDC_LIT5_HI       4
`define IDC_LIT9_HI       8
`define IDC_OFF_SEL_BIT   6
`define IDC_OFF_HI        5
`define IDC_STEP_SEL_BIT  2
`define IDC_STEP_HI       1
`define IDC_SKIPSET_BIT   10
`define IDC_JUMP_BIT      11
`define IDC_INDF0_ADDR    7'h00
`define IDC_INDF1_ADDR    7'h01
`define IDC_OP_RETURN     14'h0008
`define IDC_OP_RETURN_FROM_INTERRUPT     14'h0009
`define IDC_OP_CALL_VIA_ACCUMULATOR      14'h000a
`define IDC_OP_BRW        14'h000b
`endif

// ---- inc/idc_pkg.sv ----
// types shared by the instruction decoder modules
`default_nettype none
package idc_pkg;
   typedef enum logic [1:0] {
      IDC_CLS_BYTE   = 2'h0,
      IDC_CLS_BIT    = 2'h1,
      IDC_CLS_LITCTL = 2'h2
   } idc_class_t;
   typedef enum logic [4:0] {
      IDC_K_FILE_BYTE, IDC_K_FILE_SKIP, IDC_K_BIT_WRITE, IDC_K_BIT_SKIP,
      IDC_K_LIT8, IDC_K_ACC_CLR, IDC_K_BANK, IDC_K_CALL, IDC_K_JUMP,
      IDC_K_CALL_VIA_ACCUMULATOR, IDC_K_RET, IDC_K_RETURN_WITH_LITERAL, IDC_K_RETURN_FROM_INTERRUPT, IDC_K_BRA,
      IDC_K_BRW, IDC_K_PTR_OFF, IDC_K_PTR_STEP, IDC_K_OTHER
   } idc_kind_t;
   typedef enum logic [2:0] {
      IDC_ST_EXEC  = 3'b001,
      IDC_ST_EXTRA = 3'b010,
      IDC_ST_FLUSH = 3'b100
   } idc_state_t;
endpackage : idc_pkg
`default_nettype wire

// ---- inc/idc_fields_if.sv ----
// instruction word and its decoded fields between splitter and core
`default_nettype none
interface idc_fields_if;
   import idc_pkg::*;
   logic [13:0] word;
   idc_class_t  cls;
   idc_kind_t   kind;
   logic [6:0]  file_addr;
   logic        dest;
   logic [2:0]  bit_sel;
   logic [7:0]  lit8;
   logic [10:0] lit11;
   logic [4:0]  lit5;
   logic [8:0]  lit9;
   logic        off_sel;
   logic [5:0]  off6;
   logic        step_sel;
   logic [1:0]  step_mode;
   modport split (input word, output cls, kind, file_addr, dest, bit_sel,
                  lit8, lit11, lit5, lit9, off_sel, off6, step_sel,
                  step_mode);
   modport core (output word, input cls, kind, file_addr, dest, bit_sel,
                 lit8, lit11, lit5, lit9, off_sel, off6, step_sel,
                 step_mode);
endinterface : idc_fields_if
`default_nettype wire

// ---- core/idc_phase_gen.sv ----
// four-phase instruction cycle counter
`default_nettype none
`include "idc_defs.svh"
module idc_phase_gen #(
   parameter int PHASES = `IDC_QPHASES
) (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   output var  logic [1:0] phase,
   output var  logic       cycle_end
);
   localparam logic [1:0] LAST = 2'(PHASES - 1);
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phase <= 2'h0;
      end else if (phase == LAST) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   always_comb begin
      cycle_end = (phase == LAST);
   end
endmodule : idc_phase_gen
`default_nettype wire

// ---- core/idc_field_split.sv ----
// splits a 14-bit instruction word into class, kind and operand fields
`default_nettype none
`include "idc_defs.svh"
module idc_field_split import idc_pkg::*; (
   idc_fields_if.split f
);
   logic [1:0] top2;
   logic [3:0] op4;
   assign top2 = f.word[13:12];
   assign op4  = f.word[11:8];
   // pure slices; don't-care bits never enter any compare below
   assign f.file_addr = f.word[`IDC_FILE_HI:0];
   assign f.dest      = f.word[`IDC_DEST_BIT];
   assign f.bit_sel   = f.word[`IDC_BIT_HI:`IDC_BIT_LO];
   assign f.lit8      = f.word[`IDC_LIT8_HI:0];
   assign f.lit11     = f.word[`IDC_LIT11_HI:0];
   assign f.lit5      = f.word[`IDC_LIT5_HI:0];
   assign f.lit9      = f.word[`IDC_LIT9_HI:0];
   assign f.off_sel   = f.word[`IDC_OFF_SEL_BIT];
   assign f.off6      = f.word[`IDC_OFF_HI:0];
   assign f.step_sel  = f.word[`IDC_STEP_SEL_BIT];
   assign f.step_mode = f.word[`IDC_STEP_HI:0];
   always_comb begin
      f.cls  = IDC_CLS_LITCTL;
      f.kind = IDC_K_OTHER;
      unique case (top2)
         2'b00: begin
            if (op4 == 4'h1 && !f.word[`IDC_DEST_BIT]) begin
               f.kind = IDC_K_ACC_CLR;
            end else if (op4 != 4'h0 || f.word[`IDC_DEST_BIT]) begin
               f.cls  = IDC_CLS_BYTE;
               f.kind = (op4 == 4'hb || op4 == 4'hf) ? IDC_K_FILE_SKIP
                                                     : IDC_K_FILE_BYTE;
            end else if (f.word[6:5] == 2'b01) begin
               f.kind = IDC_K_BANK;
            end else if (f.word[7:3] == 5'h02) begin
               f.kind = IDC_K_PTR_STEP;
            end else if (f.word == `IDC_OP_RETURN) begin
               f.kind = IDC_K_RET;
            end else if (f.word == `IDC_OP_RETURN_FROM_INTERRUPT) begin
               f.kind = IDC_K_RETURN_FROM_INTERRUPT;
            end else if (f.word == `IDC_OP_CALL_VIA_ACCUMULATOR) begin
               f.kind = IDC_K_CALL_VIA_ACCUMULATOR;
            end else if (f.word == `IDC_OP_BRW) begin
               f.kind = IDC_K_BRW;
            end
         end
         2'b01: begin
            f.cls  = IDC_CLS_BIT;
            f.kind = op4[3] ? IDC_K_BIT_SKIP : IDC_K_BIT_WRITE;
         end
         2'b10: begin
            f.kind = f.word[`IDC_JUMP_BIT] ? IDC_K_JUMP : IDC_K_CALL;
         end
         2'b11: begin
            unique case (op4)
               4'h5, 4'h6, 4'h7, 4'hb, 4'hd: begin
                  f.cls  = IDC_CLS_BYTE;
                  f.kind = IDC_K_FILE_BYTE;
               end
               4'h2, 4'h3: f.kind = IDC_K_BRA;
               4'h4:       f.kind = IDC_K_RETURN_WITH_LITERAL;
               4'h1: f.kind = f.word[7] ? IDC_K_OTHER : IDC_K_PTR_OFF;
               4'hf:       f.kind = IDC_K_PTR_OFF;
               default:    f.kind = IDC_K_LIT8;
            endcase
         end
      endcase
   end
endmodule : idc_field_split
`default_nettype wire

// ---- core/idc_decoder.sv ----
// instruction decode and cycle timing for the 8-bit core
// Contract
// - each instruction is one 14-bit word
// - classify as byte, bit or literal/control
// - other instructions take one instruction cycle
// - call and call-via-accumulator take two cycles
// - all three returns take two cycles
// - jumps, branches and taken skips take two
// - indirect access to program memory adds one
// - instruction cycle is four oscillator clocks
// - file operands are read, modified, then stored
// - read happens even for write-only use
// - dest bit zero to accumulator, one to file
// - file address is seven bits, 0x00 to 0x7f
// - bit number in bits 9 to 7
// - literal 8 bits; call/jump target 11 bits
// - bank select literal in bits 4 to 0
// - relative branch displacement in bits 8 to 0
// - offset form: bit 6 pointer, 6-bit offset
// - step form: bit 2 pointer, 2-bit mode
// - don't-care bits are ignored
// - second cycle of a multi-cycle op is a no-op (the indirect extra cycle is not one: it does the store)
`default_nettype none
`include "idc_defs.svh"
module idc_decoder import idc_pkg::*; #(
   parameter int WORD_W = `IDC_WORD_W,
   parameter int PHASES = `IDC_QPHASES
) (
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire logic [WORD_W-1:0] instr_word,
   output var  logic              instr_take,
   input  wire logic [7:0]        rd_data,
   input  wire logic              zero_result,
   input  wire logic [1:0]        ptr_high,
   output var  logic [1:0]        phase,
   output var  logic              cycle_start,
   output var  idc_class_t        instr_class,
   output var  idc_kind_t         op_kind,
   output var  logic [6:0]        file_addr,
   output var  logic              dest_file,
   output var  logic [2:0]        bit_sel,
   output var  logic [7:0]        bit_mask,
   output var  logic [7:0]        lit8,
   output var  logic [10:0]       lit11,
   output var  logic [4:0]        lit5,
   output var  logic [8:0]        lit9,
   output var  logic              off_sel,
   output var  logic [5:0]        ptr_offset,
   output var  logic              step_sel,
   output var  logic [1:0]        step_mode,
   output var  logic              file_read,
   output var  logic              file_write,
   output var  logic              acc_write,
   output var  logic              nop_cycle,
   output var  logic              extra_cycle,
   output var  logic              skip_taken,
   output var  logic [1:0]        cycles_used
);
   idc_fields_if fld ();
   idc_state_t   state;
   idc_state_t   next_state;
   logic [WORD_W-1:0] ir;
   logic         cycle_end;
   logic         test_bit;
   logic         needs_extra;
   logic         pc_change;
   logic         skip_type;
   logic         skip_now;
   logic         last_exec;
   logic [1:0]   next_cycles;

   // an indirect file register goes through one of the two pointers
   function automatic logic is_indirect(input logic [6:0] addr);
      is_indirect = (addr == `IDC_INDF0_ADDR) || (addr == `IDC_INDF1_ADDR);
   endfunction : is_indirect

   function automatic logic names_file(input idc_kind_t k);
      names_file = (k == IDC_K_FILE_BYTE) || (k == IDC_K_FILE_SKIP) ||
                   (k == IDC_K_BIT_WRITE) || (k == IDC_K_BIT_SKIP);
   endfunction : names_file

   idc_phase_gen #(
      .PHASES    (PHASES)
   ) u_phase (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .phase     (phase),
      .cycle_end (cycle_end)
   );

   idc_field_split u_split (
      .f (fld)
   );

   assign fld.word = ir;

   // word fetched only at phase 0 of a fresh execute cycle
   always_comb begin
      instr_take  = (phase == 2'h0) && (state == IDC_ST_EXEC);
      cycle_start = (phase == 2'h0);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ir <= '0;
      end else if (instr_take) begin
         ir <= instr_word;
      end
   end

   // operand fields held for the rest of the instruction
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         instr_class <= IDC_CLS_LITCTL;
         op_kind     <= IDC_K_OTHER;
         file_addr   <= 7'h00;
         dest_file   <= 1'b0;
         bit_sel     <= 3'h0;
         bit_mask    <= 8'h00;
         lit8        <= 8'h00;
         lit11       <= 11'h000;
         lit5        <= 5'h00;
         lit9        <= 9'h000;
         off_sel     <= 1'b0;
         ptr_offset  <= 6'h00;
         step_sel    <= 1'b0;
         step_mode   <= 2'h0;
      end else if (phase == 2'h1 && state == IDC_ST_EXEC) begin
         instr_class <= fld.cls;
         op_kind     <= fld.kind;
         file_addr   <= fld.file_addr;
         dest_file   <= fld.dest;
         bit_sel     <= fld.bit_sel;
         bit_mask    <= 8'h01 << fld.bit_sel;
         lit8        <= fld.lit8;
         lit11       <= fld.lit11;
         lit5        <= fld.lit5;
         lit9        <= fld.lit9;
         off_sel     <= fld.off_sel;
         ptr_offset  <= fld.off6;
         step_sel    <= fld.step_sel;
         step_mode   <= fld.step_mode;
      end
   end

   // pointer msb set means the pointer reaches program memory
   always_comb begin
      needs_extra = names_file(op_kind) && is_indirect(file_addr) &&
                    ptr_high[file_addr[0]];
      pc_change   = (op_kind == IDC_K_CALL)   ||
                    (op_kind == IDC_K_CALL_VIA_ACCUMULATOR)  ||
                    (op_kind == IDC_K_RET)    ||
                    (op_kind == IDC_K_RETURN_WITH_LITERAL)  ||
                    (op_kind == IDC_K_RETURN_FROM_INTERRUPT) ||
                    (op_kind == IDC_K_JUMP)   ||
                    (op_kind == IDC_K_BRA)    ||
                    (op_kind == IDC_K_BRW);
      skip_type   = (op_kind == IDC_K_FILE_SKIP) ||
                    (op_kind == IDC_K_BIT_SKIP);
      last_exec   = (state == IDC_ST_EXTRA) ||
                    (state == IDC_ST_EXEC && !needs_extra);
   end

   // bit test uses the value read in phase 2
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         test_bit <= 1'b0;
      end else if (phase == 2'h2 && file_read) begin
         test_bit <= |(rd_data & bit_mask);
      end
   end

   // skip sense: bit 10 set tests for a set bit
   always_comb begin
      skip_now = 1'b0;
      if (op_kind == IDC_K_BIT_SKIP) begin
         skip_now = (test_bit == lit11[`IDC_SKIPSET_BIT]);
      end else if (op_kind == IDC_K_FILE_SKIP) begin
         skip_now = zero_result;
      end
   end

   // read in phase 2 of the first cycle, store in phase 3 of the last
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         file_read <= 1'b0;
      end else begin
         file_read <= (phase == 2'h1) && (state == IDC_ST_EXEC) &&
                      (fld.cls != IDC_CLS_LITCTL);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         file_write <= 1'b0;
      end else if (phase == 2'h2 && last_exec) begin
         // bit set/clear always writes back; byte ops follow dest
         file_write <= (op_kind == IDC_K_BIT_WRITE) ||
                       ((op_kind == IDC_K_FILE_BYTE ||
                         op_kind == IDC_K_FILE_SKIP) && dest_file);
      end else begin
         file_write <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acc_write <= 1'b0;
      end else if (phase == 2'h2 && last_exec) begin
         acc_write <= ((op_kind == IDC_K_FILE_BYTE ||
                        op_kind == IDC_K_FILE_SKIP) && !dest_file) ||
                      (op_kind == IDC_K_LIT8) ||
                      (op_kind == IDC_K_RETURN_WITH_LITERAL) ||
                      (op_kind == IDC_K_ACC_CLR);
      end else begin
         acc_write <= 1'b0;
      end
   end

   // next cycle chosen at the end of phase 3
   always_comb begin
      next_state = state;
      unique case (state)
         IDC_ST_EXEC: begin
            if (needs_extra) begin
               next_state = IDC_ST_EXTRA;
            end else if (pc_change || (skip_type && skip_now)) begin
               next_state = IDC_ST_FLUSH;
            end else begin
               next_state = IDC_ST_EXEC;
            end
         end
         IDC_ST_EXTRA: begin
            next_state = (pc_change || (skip_type && skip_now))
                         ? IDC_ST_FLUSH : IDC_ST_EXEC;
         end
         IDC_ST_FLUSH: next_state = IDC_ST_EXEC;
         default:      next_state = IDC_ST_EXEC;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= IDC_ST_EXEC;
      end else if (cycle_end) begin
         state <= next_state;
      end
   end

   // count of cycles spent on the current instruction, 1 to 3
   always_comb begin
      next_cycles = cycles_used;
      if (state == IDC_ST_EXEC) begin
         next_cycles = 2'h1;
      end else if (cycles_used != 2'h3) begin
         next_cycles = cycles_used + 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cycles_used <= 2'h0;
      end else if (phase == 2'h0) begin
         cycles_used <= next_cycles;
      end
   end

   // skip result stays up through the flushed cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         skip_taken <= 1'b0;
      end else if (cycle_end && last_exec) begin
         skip_taken <= skip_type && skip_now;
      end else if (cycle_end) begin
         skip_taken <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         nop_cycle   <= 1'b0;
         extra_cycle <= 1'b0;
      end else if (cycle_end) begin
         nop_cycle   <= (next_state == IDC_ST_FLUSH);
         extra_cycle <= (next_state == IDC_ST_EXTRA);
      end
   end
endmodule : idc_decoder
`default_nettype wire

// ---- tb/idc_decoder_asserts.sv ----
// port-level assertions for the instruction decoder
`default_nettype none
module idc_decoder_asserts import idc_pkg::*; (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       instr_take,
   input wire logic [1:0] phase,
   input wire idc_class_t instr_class,
   input wire idc_kind_t  op_kind,
   input wire logic       dest_file,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] bit_mask,
   input wire logic       file_read,
   input wire logic       file_write,
   input wire logic       acc_write,
   input wire logic       nop_cycle,
   input wire logic       extra_cycle,
   input wire logic       skip_taken
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_phase_step: assert property (
      !sys_rst |=> phase == $past(phase) + 2'h1)
      else $error("phase did not advance by one");
   chk_take_refused: assert property (
      instr_take |-> phase == 2'h0 && !nop_cycle && !extra_cycle)
      else $error("word taken outside an exec phase 0");
   chk_read_then_write: assert property (
      file_write && !extra_cycle |-> phase == 2'h3 && $past(file_read))
      else $error("file write without preceding read");
   chk_read_always: assert property (
      phase == 2'h2 && instr_class != IDC_CLS_LITCTL && !nop_cycle
      && !extra_cycle |-> file_read)
      else $error("file operand not read");
   chk_dest_file: assert property (
      file_write && instr_class == IDC_CLS_BYTE |-> dest_file)
      else $error("file written with dest select zero");
   chk_dest_acc: assert property (
      acc_write && instr_class == IDC_CLS_BYTE |-> !dest_file)
      else $error("accumulator written with dest select one");
   chk_bit_mask: assert property (
      phase == 2'h2 && instr_class == IDC_CLS_BIT
      |-> bit_mask == 8'h01 << bit_sel)
      else $error("bit mask does not match bit number");
   chk_branch_nop: assert property (
      phase == 2'h3 && !nop_cycle && op_kind inside {IDC_K_CALL,
      IDC_K_JUMP, IDC_K_CALL_VIA_ACCUMULATOR, IDC_K_RET, IDC_K_RETURN_WITH_LITERAL, IDC_K_RETURN_FROM_INTERRUPT,
      IDC_K_BRA, IDC_K_BRW} |=> nop_cycle [*4])
      else $error("control op lacks a flushed second cycle");
   chk_one_cycle: assert property (
      phase == 2'h3 && op_kind == IDC_K_LIT8 && !nop_cycle |=> instr_take)
      else $error("literal op took more than one cycle");
   chk_skip_nop: assert property (
      skip_taken |-> nop_cycle)
      else $error("taken skip not flushed");
   chk_extra_len: assert property (
      $rose(extra_cycle) |-> extra_cycle [*4] ##1 !extra_cycle)
      else $error("indirect extra cycle is not four clocks");
   cov_nop: cover property (nop_cycle && phase == 2'h0);
   cov_extra: cover property ($rose(extra_cycle));
   cov_skip: cover property ($rose(skip_taken));
endmodule : idc_decoder_asserts
bind idc_decoder idc_decoder_asserts u_chk (.*);
`default_nettype wire

// ---- tb/idc_prog_mem.sv ----
// program memory model feeding instruction words
`default_nettype none
module idc_prog_mem (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        instr_take,
   output var  logic [13:0] instr_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] mem [0:3];
   logic [1:0]  pc;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pc <= 2'h0;
      end else if (instr_take) begin
         pc <= pc + 2'h1;
      end
   end
   // outside a fetch show the inverse, so a stale sample is caught
   always_comb begin
      instr_word = instr_take ? mem[pc] : ~mem[pc];
   end
endmodule : idc_prog_mem
`default_nettype wire

// ---- tb/test_idc_decoder.sv ----
// self-checking bench for the instruction decoder
`default_nettype none
module test_idc_decoder import idc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, sys_rst, instr_take, zero_result, cycle_start;
   logic        dest_file, off_sel, step_sel, file_read, file_write;
   logic        acc_write, nop_cycle, extra_cycle, skip_taken;
   logic [13:0] instr_word;
   logic [10:0] lit11;
   logic [8:0]  lit9;
   logic [7:0]  rd_data, bit_mask, lit8;
   logic [6:0]  file_addr;
   logic [5:0]  ptr_offset;
   logic [4:0]  lit5;
   logic [2:0]  bit_sel;
   logic [1:0]  ptr_high, phase, step_mode, cycles_used;
   idc_class_t  instr_class;
   idc_kind_t   op_kind;
   logic        seen_read, seen_write, seen_acc, seen_nop, seen_extra;
   logic        seen_skip;
   int          n_clk;
   int          bad_count = 0;
   int          n_compared = 0;

   idc_decoder dut (.*);
   idc_prog_mem pm (.*);

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic expect_ok(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("Error at %0t ns: %s", $time, what);
      end
   endtask : expect_ok

   // reset, run one word, count clocks until the next fetch
   task automatic run_word(input logic [13:0] w, input int ncyc);
      pm.mem[0] = w;
      sys_rst = 1'b1;
      repeat (8) @(posedge mclk);
      #1 sys_rst = 1'b0;
      {seen_read, seen_write, seen_acc, seen_nop, seen_extra} = '0;
      seen_skip = 1'b0;
      // the word is taken at the first edge after release, so count it
      n_clk = 0;
      do begin
         @(posedge mclk);
         #1 n_clk++;
         seen_read |= (file_read === 1'b1);
         seen_write |= (file_write === 1'b1);
         seen_acc |= (acc_write === 1'b1);
         seen_nop |= (nop_cycle === 1'b1);
         seen_extra |= (extra_cycle === 1'b1);
         seen_skip |= (skip_taken === 1'b1);
      end while (instr_take !== 1'b1 && n_clk < 16);
      expect_ok(n_clk == 4 * ncyc, "instruction length wrong");
      expect_ok(cycles_used === 2'(ncyc) && cycle_start, "count");
      // let the next fetch edge pass so end-of-instruction checks complete
      @(posedge mclk);
      #1;
   endtask : run_word

   task automatic t_byte_ops;
      run_word(14'h07a0, 1);
      expect_ok(instr_class === IDC_CLS_BYTE, "byte class");
      expect_ok(file_addr === 7'h20 && dest_file === 1'b1, "fields");
      expect_ok(seen_read && seen_write && !seen_acc, "to file");
      run_word(14'h0720, 1);
      expect_ok(seen_acc && !seen_write, "to accumulator");
      run_word(14'h00ff, 1);
      expect_ok(seen_read && file_addr === 7'h7f, "write-only");
      $display("byte ops done");
   endtask : t_byte_ops

   task automatic t_bit_ops;
      rd_data = 8'h20;
      run_word(14'h1e90, 2);
      expect_ok(instr_class === IDC_CLS_BIT, "bit class");
      expect_ok(bit_sel === 3'h5 && bit_mask === 8'h20, "bit no");
      expect_ok(seen_nop && seen_skip, "skip flushed");
      rd_data = 8'hdf;
      run_word(14'h1e90, 1);
      expect_ok(!seen_nop && !seen_skip, "skip not taken");
      run_word(14'h1a90, 2);
      run_word(14'h1785, 1);
      expect_ok(seen_write && bit_mask === 8'h80, "bit set");
      $display("bit ops done");
   endtask : t_bit_ops

   task automatic t_count_skip;
      zero_result = 1'b1;
      run_word(14'h0ba0, 2);
      run_word(14'h0fa0, 2);
      zero_result = 1'b0;
      run_word(14'h0ba0, 1);
      expect_ok(!seen_nop, "count skip not taken");
      $display("count skips done");
   endtask : t_count_skip

   task automatic t_control;
      logic [13:0] w [6] = '{14'h2123, 14'h2ccc, 14'h0008, 14'h0009,
                             14'h000a, 14'h000b};
      idc_kind_t   k [6] = '{IDC_K_CALL, IDC_K_JUMP, IDC_K_RET,
                             IDC_K_RETURN_FROM_INTERRUPT, IDC_K_CALL_VIA_ACCUMULATOR, IDC_K_BRW};
      for (int i = 0; i < 6; i++) begin
         run_word(w[i], 2);
         expect_ok(op_kind === k[i] && seen_nop, "control");
      end
      run_word(14'h27ff, 2);
      expect_ok(lit11 === 11'h7ff, "call target");
      run_word(14'h33ff, 2);
      expect_ok(op_kind === IDC_K_BRA && lit9 === 9'h1ff, "branch");
      $display("control ops done");
   endtask : t_control

   task automatic t_literals;
      run_word(14'h30a5, 1);
      expect_ok(lit8 === 8'ha5 && seen_acc, "literal");
      expect_ok(instr_class === IDC_CLS_LITCTL, "literal class");
      run_word(14'h003f, 1);
      expect_ok(op_kind === IDC_K_BANK && lit5 === 5'h1f, "bank");
      run_word(14'h317f, 1);
      expect_ok(off_sel === 1'b1 && ptr_offset === 6'h3f, "offset");
      for (int m = 0; m < 4; m++) begin
         run_word(14'h0014 | 14'(m), 1);
         expect_ok(op_kind === IDC_K_PTR_STEP && step_sel === 1'b1
                   && step_mode === 2'(m), "step form");
      end
      run_word(14'h0103, 1);
      expect_ok(op_kind === IDC_K_ACC_CLR, "don't-care bits");
      $display("literal ops done");
   endtask : t_literals

   task automatic t_indirect;
      ptr_high = 2'h1;
      run_word(14'h0780, 2);
      expect_ok(seen_extra && seen_write, "indirect extra");
      zero_result = 1'b1;
      run_word(14'h0b80, 3);
      zero_result = 1'b0;
      ptr_high = 2'h2;
      run_word(14'h0780, 1);
      expect_ok(!seen_extra, "data pointer no extra");
      run_word(14'h0781, 2);
      ptr_high = 2'h0;
      $display("indirect ops done");
   endtask : t_indirect

   initial begin
      sys_rst = 1'b1;
      rd_data = 8'h00;
      zero_result = 1'b0;
      ptr_high = 2'h0;
      for (int i = 0; i < 4; i++) begin
         pm.mem[i] = 14'h3000;
      end
      @(posedge mclk);
      #1;
      t_byte_ops();
      t_bit_ops();
      t_count_skip();
      t_control();
      t_literals();
      t_indirect();
      give_verdict();
   end

   // whole run needs well under a thousand clocks
   initial begin
      #2000000;
      bad_count++;
      $display("Error at %0t ns: watchdog expired", $time);
      give_verdict();
   end
endmodule : test_idc_decoder
`default_nettype wire
